// ===== logic/uec_device_end.sv
// USB device endpoint core: endpoint buffers in shared RAM, DMA handler,
// speed detection and software register port.
// Assumes the far end drives the link on the same clock; software uses the
// plain strobe port with read data one cycle after the read strobe.
`timescale 1ns/1ps
`default_nettype none
module uec_device_end
  import uec_pkg::*;
#(
  parameter int IDLE_CYC = HS_IDLE_CYC,
  parameter int SE0_MIN = SE0_MIN_CYC,
  parameter int SE0_MAX = SE0_MAX_CYC
) (
  input wire logic CLK,
  input wire logic NRST,
  input wire logic CE,
  uec_link_if.dev_mp LNK,
  input wire logic [7:0] ADDR,
  input wire logic [31:0] WDATA,
  input wire logic WR,
  input wire logic RD,
  output logic [31:0] RDATA,
  output logic SUSPEND
);
  typedef struct packed {
    uec_speed_t spd;
    logic [19:0] tmr;
    logic [19:0] se0_tmr;
    logic suspended;
    logic [4:0] sel;
    uec_ep_t [SLOTS-1:0] ep;
    logic dma_hs;
    logic dma_busy;
    logic dma_dir;
    logic [4:0] dma_slot;
    logic [9:0] dma_left;
    logic dma_have;
    logic dma_rdp;
    logic [15:0] dma_word;
    logic in_busy;
    logic [4:0] in_slot;
    logic [9:0] in_left;
    logic in_pend;
    logic in_lastp;
    logic in_nak;
    logic [31:0] rdata;
    logic rd_ram;
    logic srp;
    logic setup_seen;
  } uec_dev_st_t;

  uec_dev_st_t s;
  uec_dev_st_t n;
  logic [15:0] ram [RAM_WORDS];
  logic [15:0] ram_q;
  logic ram_we;
  logic ram_re;
  logic [11:0] ram_a;
  logic [15:0] ram_d;
  logic uc_ram;
  logic usb_ram;
  logic stb_rd;
  logic stb_wr;
  logic [4:0] cmd_slot;
  uec_ep_t ue;
  uec_ep_t oe;
  uec_ep_t ie;
  uec_ep_t be;
  uec_ep_t de;
  uec_ep_t ce_ep;

  // Word address inside an endpoint's half-buffer
  function automatic logic [11:0] buf_addr(uec_ep_t e, logic sel, logic [9:0] p);
    buf_addr = e.base + (sel ? {2'h0, e.maxw} : 12'h000) + {2'h0, p};
  endfunction : buf_addr

  function automatic logic is_out(logic [4:0] k);
    is_out = (k <= SLOT_CTRL_OUT) || (k >= SLOT_OUT1 && k < SLOT_IN1);
  endfunction : is_out

  function automatic logic is_in(logic [4:0] k);
    is_in = (k == SLOT_CTRL_IN) || (k >= SLOT_IN1 && k < SLOT_END);
  endfunction : is_in

  // Release the read half after the last word leaves, by any reader
  function automatic uec_ep_t free_rd(uec_ep_t e);
    free_rd = e;
    free_rd.full[e.rsel] = 1'b0;
    free_rd.rptr = 10'h000;
    free_rd.rsel = e.rsel ^ e.dbl;
  endfunction : free_rd

  // Hand a filled write half to the reader side
  function automatic uec_ep_t fill_wr(uec_ep_t e, logic [9:0] c);
    fill_wr = e;
    fill_wr.full[e.wsel] = 1'b1;
    fill_wr.cnt[e.wsel] = c;
    fill_wr.wptr = 10'h000;
    fill_wr.wsel = e.wsel ^ e.dbl;
  endfunction : fill_wr

  assign cmd_slot = WDATA[DMA_SLOT_LSB +: 5];
  assign ue = s.ep[s.sel];
  assign oe = s.ep[LNK.out_slot];
  assign ie = s.ep[LNK.in_slot];
  assign be = s.ep[s.in_slot];
  assign de = s.ep[s.dma_slot];
  assign ce_ep = s.ep[cmd_slot];
  // Acknowledge qualifies a strobe only in handshake mode
  assign stb_rd = LNK.dma_read_strobe && (!s.dma_hs || LNK.dma_acknowledge) && s.dma_busy
    && !s.dma_dir && s.dma_have;
  assign stb_wr = LNK.dma_write_strobe && (!s.dma_hs || LNK.dma_acknowledge) && s.dma_busy
    && s.dma_dir && !s.dma_have;

  // Next state; RAM port order is software, then USB, then DMA
  always_comb begin
    n = s;
    ram_we = 1'b0;
    ram_re = 1'b0;
    ram_a = 12'h000;
    ram_d = 16'h0000;
    uc_ram = 1'b0;
    usb_ram = 1'b0;
    n.srp = 1'b0;
    n.rd_ram = 1'b0;
    n.in_pend = 1'b0;
    n.in_lastp = 1'b0;
    n.in_nak = 1'b0;
    n.dma_rdp = 1'b0;
    // Software writes; clear and commit act on the slot selected before
    if (WR) begin
      case (ADDR)
        REG_CTRL: begin
          n.sel = WDATA[CTRL_SEL_LSB +: 5];
          n.srp = WDATA[CTRL_SRP];
          if (WDATA[CTRL_CLR] && is_out(s.sel)) begin
            n.ep[s.sel].full = 2'h0;
            n.ep[s.sel].wptr = 10'h000;
            n.ep[s.sel].rptr = 10'h000;
            n.ep[s.sel].wsel = 1'b0;
            n.ep[s.sel].rsel = 1'b0;
          end
          if (WDATA[CTRL_COMMIT] && is_in(s.sel) && !ue.full[ue.wsel] && ue.wptr != 10'h000) begin
            n.ep[s.sel] = fill_wr(ue, ue.wptr);
          end
        end
        REG_EP_CFG: begin
          if (s.sel >= SLOT_OUT1 && s.sel < SLOT_END) begin
            n.ep[s.sel].en = WDATA[CFG_EN];
            n.ep[s.sel].typ = WDATA[CFG_TYPE_LSB +: 2];
            n.ep[s.sel].dbl = WDATA[CFG_DBL];
            n.ep[s.sel].maxw = WDATA[CFG_MAXW_LSB +: 10];
            n.ep[s.sel].base = WDATA[CFG_BASE_LSB +: 12];
          end
        end
        REG_EP_DATA: begin
          if (is_in(s.sel) && !ue.full[ue.wsel] && ue.wptr < ue.maxw) begin
            ram_we = 1'b1;
            uc_ram = 1'b1;
            ram_a = buf_addr(ue, ue.wsel, ue.wptr);
            ram_d = WDATA[15:0];
            n.ep[s.sel].wptr = ue.wptr + 10'h001;
          end
        end
        REG_DMA_CFG: n.dma_hs = WDATA[DMA_CFG_HS];
        REG_DMA_CMD: begin
          if (WDATA[DMA_GO] && !s.dma_busy) begin
            n.dma_slot = cmd_slot;
            n.dma_dir = WDATA[DMA_DIR];
            n.dma_have = 1'b0;
            // Word counts assume buffers sized in whole 16-bit words
            if (!WDATA[DMA_DIR] && is_out(cmd_slot) && ce_ep.full[ce_ep.rsel]) begin
              n.dma_busy = 1'b1;
              n.dma_left = ce_ep.cnt[ce_ep.rsel];
              n.ep[cmd_slot].rptr = 10'h000;
            end else if (WDATA[DMA_DIR] && is_in(cmd_slot) && !ce_ep.full[ce_ep.wsel]) begin
              n.dma_busy = ce_ep.maxw != 10'h000;
              n.dma_left = ce_ep.maxw;
              n.ep[cmd_slot].wptr = 10'h000;
            end
          end
        end
        default: ;
      endcase
    end
    // Software reads; data port pops a word and frees the half at its end
    if (RD) begin
      n.rdata = 32'h00000000;
      case (ADDR)
        REG_CTRL: n.rdata = {19'h00000, s.sel, 8'h00};
        REG_EP_CFG: n.rdata = {4'h0, ue.base, 2'h0, ue.maxw, ue.dbl, ue.typ, ue.en};
        REG_EP_STAT: n.rdata = {16'h0000, ue.full, ue.rsel, ue.wsel, 2'h0, ue.cnt[ue.rsel]};
        REG_DMA_CFG: n.rdata = {31'h00000000, s.dma_hs};
        REG_DMA_CMD: n.rdata = {s.dma_busy, 14'h0000, s.dma_slot, 1'b0, s.dma_left, s.dma_dir};
        REG_STATUS: begin
          n.rdata = {26'h0000000, s.spd, s.suspended, s.dma_busy, s.setup_seen, 1'b0};
          n.setup_seen = 1'b0;
        end
        REG_EP_DATA: begin
          if (is_out(s.sel) && ue.full[ue.rsel]) begin
            ram_re = 1'b1;
            uc_ram = 1'b1;
            n.rd_ram = 1'b1;
            ram_a = buf_addr(ue, ue.rsel, ue.rptr);
            n.ep[s.sel].rptr = ue.rptr + 10'h001;
            if (ue.rptr + 10'h001 >= ue.cnt[ue.rsel]) begin
              n.ep[s.sel] = free_rd(ue);
            end
          end
        end
        default: ;
      endcase
    end
    // USB OUT words land in the write half; setup is left to firmware
    if (LNK.out_valid && !uc_ram && is_out(LNK.out_slot) && oe.en && !oe.full[oe.wsel]) begin
      if (oe.wptr < oe.maxw) begin
        ram_we = 1'b1;
        usb_ram = 1'b1;
        ram_a = buf_addr(oe, oe.wsel, oe.wptr);
        ram_d = LNK.out_data;
        n.ep[LNK.out_slot].wptr = oe.wptr + 10'h001;
      end
      if (LNK.out_last) begin
        n.ep[LNK.out_slot] = fill_wr(oe, n.ep[LNK.out_slot].wptr);
        if (LNK.out_slot == SLOT_SETUP) begin
          n.setup_seen = 1'b1;
        end
      end
    end
    // USB IN: start on request, or stream one word per free RAM cycle
    if (LNK.in_req && !s.in_busy) begin
      if (is_in(LNK.in_slot) && ie.en && ie.full[ie.rsel]) begin
        n.in_busy = 1'b1;
        n.in_slot = LNK.in_slot;
        n.in_left = ie.cnt[ie.rsel];
        n.ep[LNK.in_slot].rptr = 10'h000;
      end else begin
        n.in_nak = 1'b1;
      end
    // An OUT word in the same cycle owns the RAM port; streaming waits a cycle
    end else if (s.in_busy && !uc_ram && !usb_ram) begin
      ram_re = 1'b1;
      usb_ram = 1'b1;
      ram_a = buf_addr(be, be.rsel, be.rptr);
      n.in_pend = 1'b1;
      n.in_left = s.in_left - 10'h001;
      n.ep[s.in_slot].rptr = be.rptr + 10'h001;
      if (s.in_left == 10'h001) begin
        n.in_lastp = 1'b1;
        n.in_busy = 1'b0;
        n.ep[s.in_slot] = free_rd(be);
      end
    end
    // DMA handler takes the RAM only when nobody else does
    if (s.dma_rdp) begin
      n.dma_have = 1'b1;
      n.dma_word = ram_q;
    end
    if (stb_rd) begin
      n.dma_have = 1'b0;
      n.dma_left = s.dma_left - 10'h001;
      if (s.dma_left == 10'h001) begin
        n.dma_busy = 1'b0;
        n.ep[s.dma_slot] = free_rd(de);
      end
    end else if (s.dma_busy && !s.dma_dir && !s.dma_have && !s.dma_rdp && !uc_ram && !usb_ram) begin
      ram_re = 1'b1;
      ram_a = buf_addr(de, de.rsel, de.rptr);
      n.dma_rdp = 1'b1;
      n.ep[s.dma_slot].rptr = de.rptr + 10'h001;
    end
    if (stb_wr) begin
      n.dma_have = 1'b1;
      n.dma_word = LNK.dma_din;
    end else if (s.dma_busy && s.dma_dir && s.dma_have && !uc_ram && !usb_ram) begin
      ram_we = 1'b1;
      ram_a = buf_addr(de, de.wsel, de.wptr);
      ram_d = s.dma_word;
      n.dma_have = 1'b0;
      n.dma_left = s.dma_left - 10'h001;
      n.ep[s.dma_slot].wptr = de.wptr + 10'h001;
      if (s.dma_left == 10'h001) begin
        n.dma_busy = 1'b0;
        n.ep[s.dma_slot] = fill_wr(de, de.wptr + 10'h001);
      end
    end
    // Speed detection
    unique case (s.spd)
      SPD_FS: begin
        if (LNK.activity) begin
          n.suspended = 1'b0;
        end
        if (LNK.bus_reset) begin
          n.spd = SPD_CHIRP;
          n.suspended = 1'b0;
        end
      end
      SPD_CHIRP: begin
        n.tmr = 20'h00000;
        if (LNK.host_chirp) begin
          n.spd = SPD_HS;
        end else if (!LNK.bus_reset) begin
          n.spd = SPD_FS;
        end
      end
      SPD_HS: begin
        n.tmr = LNK.activity ? 20'h00000 : s.tmr + 20'h00001;
        if (s.tmr == 20'(IDLE_CYC - 1)) begin
          n.spd = SPD_REVERT;
          n.tmr = 20'h00000;
          n.se0_tmr = 20'h00000;
        end
      end
      SPD_REVERT: begin
        n.tmr = s.tmr + 20'h00001;
        n.se0_tmr = LNK.se0 ? s.se0_tmr + 20'h00001 : 20'h00000;
        if (s.se0_tmr == 20'(SE0_MIN - 1)) begin
          n.spd = SPD_CHIRP;
        end else if (s.tmr == 20'(SE0_MAX - 1)) begin
          n.spd = SPD_FS;
          n.suspended = 1'b1;
        end
      end
    endcase
  end

  // State register; fixed endpoints come out of reset configured
  always_ff @(posedge CLK or negedge NRST) begin
    if (!NRST) begin
      s <= '0;
      s.ep[SLOT_SETUP] <= EP_SETUP_RST;
      s.ep[SLOT_CTRL_OUT] <= EP_COUT_RST;
      s.ep[SLOT_CTRL_IN] <= EP_CIN_RST;
    end else if (CE) begin
      s <= n;
    end
  end

  // Single-port buffer RAM with registered read
  always_ff @(posedge CLK) begin
    if (CE) begin
      if (ram_we) begin
        ram[ram_a] <= ram_d;
      end
      if (ram_re) begin
        ram_q <= ram[ram_a];
      end
    end
  end

  // Outputs; the core clock stands in for the 480 MHz sampling domain
  assign LNK.dev_chirp = s.spd == SPD_CHIRP;
  assign LNK.hs_mode = s.spd == SPD_HS;
  assign LNK.srp = s.srp;
  assign LNK.out_ready = !uc_ram;
  assign LNK.in_valid = s.in_pend;
  assign LNK.in_data = ram_q;
  assign LNK.in_last = s.in_lastp;
  assign LNK.in_nak = s.in_nak;
  assign LNK.dma_request = s.dma_busy && (s.dma_dir ? !s.dma_have : s.dma_have);
  assign LNK.dma_dir = s.dma_dir;
  assign LNK.dma_dout = s.dma_word;
  assign RDATA = s.rd_ram ? {16'h0000, ram_q} : s.rdata;
  assign SUSPEND = s.suspended;
endmodule : uec_device_end
`default_nettype wire

// ===== logic/uec_pkg.sv
// Shared constants and types for the USB device endpoint core and its far end.
// Assumes a single 250 MHz core clock shared by both ends of the link.
package uec_pkg;
  // Endpoint slots: setup, control OUT, control IN, seven OUT, seven IN
  localparam int SLOTS = 17;
  localparam logic [4:0] SLOT_SETUP = 5'h00;
  localparam logic [4:0] SLOT_CTRL_OUT = 5'h01;
  localparam logic [4:0] SLOT_CTRL_IN = 5'h02;
  localparam logic [4:0] SLOT_OUT1 = 5'h03;
  localparam logic [4:0] SLOT_IN1 = 5'h0A;
  localparam logic [4:0] SLOT_END = 5'h11;
  // Shared buffer RAM of 8 kB in 16-bit words
  localparam int RAM_BYTES = 8192;
  localparam int RAM_WORDS = RAM_BYTES / 2;
  // Register offsets of the software port
  localparam logic [7:0] REG_CTRL = 8'h00;
  localparam logic [7:0] REG_EP_CFG = 8'h04;
  localparam logic [7:0] REG_EP_DATA = 8'h08;
  localparam logic [7:0] REG_EP_STAT = 8'h0C;
  localparam logic [7:0] REG_DMA_CFG = 8'h10;
  localparam logic [7:0] REG_DMA_CMD = 8'h14;
  localparam logic [7:0] REG_STATUS = 8'h18;
  // Field positions
  localparam int CTRL_SRP = 0;
  localparam int CTRL_CLR = 1;
  localparam int CTRL_COMMIT = 2;
  localparam int CTRL_SEL_LSB = 8;
  localparam int CFG_EN = 0;
  localparam int CFG_TYPE_LSB = 1;
  localparam int CFG_DBL = 3;
  localparam int CFG_MAXW_LSB = 4;
  localparam int CFG_BASE_LSB = 16;
  localparam int DMA_CFG_HS = 0;
  localparam int DMA_DIR = 0;
  localparam int DMA_SLOT_LSB = 8;
  localparam int DMA_GO = 31;
  // Transfer types of configurable endpoints
  localparam logic [1:0] EPT_INTR = 2'h0;
  localparam logic [1:0] EPT_ISO = 2'h1;
  localparam logic [1:0] EPT_BULK = 2'h2;
  // Timing
  localparam int CLK_MHZ = 250;
  localparam int REF_MHZ = 12;
  localparam int PLL_MULT = 40;
  localparam int SAMPLE_MHZ = REF_MHZ * PLL_MULT;
  localparam int HS_IDLE_US = 3000;
  localparam int SE0_MIN_US = 100;
  localparam int SE0_MAX_US = 875;
  localparam int HS_IDLE_CYC = HS_IDLE_US * CLK_MHZ;
  localparam int SE0_MIN_CYC = SE0_MIN_US * CLK_MHZ;
  localparam int SE0_MAX_CYC = SE0_MAX_US * CLK_MHZ;

  typedef enum logic [1:0] {SPD_FS, SPD_CHIRP, SPD_HS, SPD_REVERT} uec_speed_t;

  // Per-endpoint configuration and buffer bookkeeping
  typedef struct packed {
    logic en;
    logic [1:0] typ;
    logic dbl;
    logic [9:0] maxw;
    logic [11:0] base;
    logic wsel;
    logic rsel;
    logic [1:0] full;
    logic [1:0][9:0] cnt;
    logic [9:0] wptr;
    logic [9:0] rptr;
  } uec_ep_t;

  // Reset values of the three fixed endpoints (8 B setup, 64 B control)
  localparam uec_ep_t EP_SETUP_RST = '{en: 1'b1, maxw: 10'h004, base: 12'h000, default: '0};
  localparam uec_ep_t EP_COUT_RST = '{en: 1'b1, maxw: 10'h020, base: 12'h004, default: '0};
  localparam uec_ep_t EP_CIN_RST = '{en: 1'b1, maxw: 10'h020, base: 12'h024, default: '0};
endpackage : uec_pkg

// ===== logic/uec_link_if.sv
// Link between the endpoint core and the far party (host bus and DMA device).
// Assumes both ends run on the same clock CLK.
`timescale 1ns/1ps
`default_nettype none
interface uec_link_if (input wire logic CLK);
  logic bus_reset;
  logic se0;
  logic activity;
  logic host_chirp;
  logic dev_chirp;
  logic hs_mode;
  logic srp;
  logic out_valid;
  logic [4:0] out_slot;
  logic [15:0] out_data;
  logic out_last;
  logic out_ready;
  logic in_req;
  logic [4:0] in_slot;
  logic in_valid;
  logic [15:0] in_data;
  logic in_last;
  logic in_nak;
  logic dma_request;
  logic dma_dir;
  logic [15:0] dma_dout;
  logic dma_acknowledge;
  logic dma_read_strobe;
  logic dma_write_strobe;
  logic [15:0] dma_din;

  modport dev_mp (
    input bus_reset, se0, activity, host_chirp, out_valid, out_slot, out_data, out_last,
    in_req, in_slot, dma_acknowledge, dma_read_strobe, dma_write_strobe, dma_din,
    output dev_chirp, hs_mode, srp, out_ready, in_valid, in_data, in_last, in_nak,
    dma_request, dma_dir, dma_dout
  );
  modport far_mp (
    output bus_reset, se0, activity, host_chirp, out_valid, out_slot, out_data, out_last,
    in_req, in_slot, dma_acknowledge, dma_read_strobe, dma_write_strobe, dma_din,
    input dev_chirp, hs_mode, srp, out_ready, in_valid, in_data, in_last, in_nak,
    dma_request, dma_dir, dma_dout
  );
endinterface : uec_link_if
`default_nettype wire

// ===== logic/uec_far_end.sv
// Far party: host bus stimulus pass-through, chirp answer and DMA device.
// Assumes the device end on the other side of uec_link_if, same clock.
`timescale 1ns/1ps
`default_nettype none
module uec_far_end
  import uec_pkg::*;
(
  input wire logic CLK,
  input wire logic NRST,
  input wire logic CE,
  uec_link_if.far_mp LNK,
  input wire logic BUS_RESET,
  input wire logic SE0,
  input wire logic ACTIVITY,
  input wire logic HS_CAPABLE,
  input wire logic OUT_VALID,
  input wire logic [4:0] OUT_SLOT,
  input wire logic [15:0] OUT_DATA,
  input wire logic OUT_LAST,
  output logic OUT_READY,
  input wire logic IN_REQ,
  input wire logic [4:0] IN_SLOT,
  output logic IN_VALID,
  output logic [15:0] IN_DATA,
  output logic IN_LAST,
  output logic IN_NAK,
  output logic HS_MODE,
  output logic SRP_SEEN,
  input wire logic DMA_HANDSHAKE,
  input wire logic [15:0] DMA_TX_DATA,
  output logic DMA_TX_TAKE,
  output logic [15:0] DMA_RX_DATA,
  output logic DMA_RX_VALID
);
  typedef struct packed {
    logic host_chirp;
    logic stb;
    logic [15:0] rx_data;
    logic rx_valid;
    logic srp_seen;
  } uec_far_st_t;

  uec_far_st_t s;
  uec_far_st_t n;

  // Next state: chirp answer and one strobe per request, spaced two cycles
  always_comb begin
    n = s;
    n.rx_valid = 1'b0;
    // Answer the device chirp only while resetting the bus and fast-capable
    n.host_chirp = BUS_RESET && HS_CAPABLE && LNK.dev_chirp;
    // Strobe gap lets the device drop its request before we look again
    n.stb = LNK.dma_request && !s.stb;
    if (s.stb && !LNK.dma_dir) begin
      n.rx_data = LNK.dma_dout;
      n.rx_valid = 1'b1;
    end
    if (LNK.srp) begin
      n.srp_seen = 1'b1;
    end
  end

  // State register
  always_ff @(posedge CLK or negedge NRST) begin
    if (!NRST) begin
      s <= '0;
    end else if (CE) begin
      s <= n;
    end
  end

  // Bus side passes straight through; strobes come from the spaced flop
  assign LNK.bus_reset = BUS_RESET;
  assign LNK.se0 = SE0;
  assign LNK.activity = ACTIVITY;
  assign LNK.host_chirp = s.host_chirp;
  assign LNK.out_valid = OUT_VALID;
  assign LNK.out_slot = OUT_SLOT;
  assign LNK.out_data = OUT_DATA;
  assign LNK.out_last = OUT_LAST;
  assign LNK.in_req = IN_REQ;
  assign LNK.in_slot = IN_SLOT;
  assign LNK.dma_read_strobe = s.stb && !LNK.dma_dir;
  assign LNK.dma_write_strobe = s.stb && LNK.dma_dir;
  assign LNK.dma_acknowledge = s.stb && DMA_HANDSHAKE;
  assign LNK.dma_din = DMA_TX_DATA;
  assign OUT_READY = LNK.out_ready;
  assign IN_VALID = LNK.in_valid;
  assign IN_DATA = LNK.in_data;
  assign IN_LAST = LNK.in_last;
  assign IN_NAK = LNK.in_nak;
  assign HS_MODE = LNK.hs_mode;
  assign SRP_SEEN = s.srp_seen;
  assign DMA_TX_TAKE = s.stb && LNK.dma_dir;
  assign DMA_RX_DATA = s.rx_data;
  assign DMA_RX_VALID = s.rx_valid;
endmodule : uec_far_end
`default_nettype wire

// ===== dv/uec_sva.sv
// Checker for the link that joins the device end to the far end.
// Assumes it is instantiated beside the link interface, on one clock.
`timescale 1ns/1ps
`default_nettype none
module uec_sva_chk #(
  parameter int IDLE_CYC = 200
) (
  input wire logic CLK,
  input wire logic NRST,
  input wire logic bus_reset,
  input wire logic se0,
  input wire logic activity,
  input wire logic host_chirp,
  input wire logic dev_chirp,
  input wire logic hs_mode,
  input wire logic srp,
  input wire logic in_valid,
  input wire logic in_nak,
  input wire logic dma_request,
  input wire logic [15:0] dma_dout,
  input wire logic dma_acknowledge,
  input wire logic dma_read_strobe,
  input wire logic dma_write_strobe
);
  logic [31:0] idle_cnt_reg;
  // Idle cycles in high speed; a missed timer shows up as a runaway count
  always_ff @(posedge CLK or negedge NRST) begin
    if (!NRST) begin
      idle_cnt_reg <= 32'h0;
    end else if (!hs_mode || activity) begin
      idle_cnt_reg <= 32'h0;
    end else begin
      idle_cnt_reg <= idle_cnt_reg + 32'h1;
    end
  end
  default clocking @(posedge CLK); endclocking
  default disable iff (!NRST);
  // One counted DMA word in handshake mode: strobe with acknowledge while requested
  sequence dma_take_s;
    dma_request && dma_acknowledge && (dma_read_strobe || dma_write_strobe);
  endsequence
  srp_pulse_a: assert property (srp |=> !srp) else $error("srp longer than one cycle");
  chirp_cause_a: assert property ($rose(dev_chirp) |-> $past(bus_reset) || $past(se0))
    else $error("chirp without reset or se0");
  hs_entry_a: assert property ($rose(hs_mode) |-> $past(host_chirp) && $past(dev_chirp))
    else $error("high speed without chirp answer");
  speed_excl_a: assert property (!(hs_mode && dev_chirp)) else $error("chirp in high speed");
  idle_revert_a: assert property (idle_cnt_reg <= IDLE_CYC + 2)
    else $error("high speed kept past idle limit");
  dma_drop_a: assert property (dma_take_s |=> !dma_request) else $error("request kept");
  dma_hold_a: assert property (dma_request && $past(dma_request) |-> $stable(dma_dout))
    else $error("dma data moved under request");
  in_excl_a: assert property (in_nak |-> !in_valid) else $error("nak with data");
endmodule : uec_sva_chk
`default_nettype wire

// ===== dv/usb_device_endpoint_core_bench.sv
// Self-checking bench: device end and far end joined by the link.
// Assumes shortened speed timers at the device instance.
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, ex, got) begin cmp_count++; if ((got) !== (ex)) begin err_total++; \
  $display("Error %s expected %h seen %h", nm, ex, got); end end
module usb_device_endpoint_core_bench
  import uec_pkg::*;
;
  logic clk, nrst, wr, rd, suspend, bus_reset, se0, activity, hs_cap, out_valid, out_last;
  logic out_ready, in_req, in_valid, in_last, in_nak, hs_mode, srp_seen, dma_hs, dma_take;
  logic dma_rx_valid, seen, ce;
  logic [7:0] addr;
  logic [31:0] wdata, rdata, d;
  logic [4:0] out_slot, in_slot;
  logic [15:0] out_data, in_data, dma_rx_data, dma_tx_data;
  int err_total, cmp_count, n;
  uec_link_if i_uec_link_if (.CLK(clk));
  uec_device_end #(.IDLE_CYC(200), .SE0_MIN(20), .SE0_MAX(150)) i_uec_device_end (.CLK(clk),
    .NRST(nrst), .CE(ce), .LNK(i_uec_link_if.dev_mp), .ADDR(addr), .WDATA(wdata), .WR(wr),
    .RD(rd), .RDATA(rdata), .SUSPEND(suspend));
  uec_far_end i_uec_far_end (.CLK(clk), .NRST(nrst), .CE(ce), .LNK(i_uec_link_if.far_mp),
    .BUS_RESET(bus_reset), .SE0(se0), .ACTIVITY(activity), .HS_CAPABLE(hs_cap),
    .OUT_VALID(out_valid), .OUT_SLOT(out_slot), .OUT_DATA(out_data), .OUT_LAST(out_last),
    .OUT_READY(out_ready), .IN_REQ(in_req), .IN_SLOT(in_slot), .IN_VALID(in_valid),
    .IN_DATA(in_data), .IN_LAST(in_last), .IN_NAK(in_nak), .HS_MODE(hs_mode),
    .SRP_SEEN(srp_seen), .DMA_HANDSHAKE(dma_hs), .DMA_TX_DATA(dma_tx_data), .DMA_TX_TAKE(dma_take),
    .DMA_RX_DATA(dma_rx_data), .DMA_RX_VALID(dma_rx_valid));
  uec_sva_chk #(.IDLE_CYC(200)) i_uec_sva_chk (.CLK(clk), .NRST(nrst),
    .bus_reset(i_uec_link_if.bus_reset), .se0(i_uec_link_if.se0),
    .activity(i_uec_link_if.activity), .host_chirp(i_uec_link_if.host_chirp),
    .dev_chirp(i_uec_link_if.dev_chirp), .hs_mode(i_uec_link_if.hs_mode),
    .srp(i_uec_link_if.srp), .in_valid(i_uec_link_if.in_valid), .in_nak(i_uec_link_if.in_nak),
    .dma_request(i_uec_link_if.dma_request), .dma_dout(i_uec_link_if.dma_dout),
    .dma_acknowledge(i_uec_link_if.dma_acknowledge),
    .dma_read_strobe(i_uec_link_if.dma_read_strobe),
    .dma_write_strobe(i_uec_link_if.dma_write_strobe));
  // 250 MHz core clock
  initial begin
    clk = 1'h0;
    forever #2 clk = ~clk;
  end
  task give_verdict;
    $display("Comparisons %0d, mismatches %0d", cmp_count, err_total);
    if (err_total == 0 && cmp_count > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask : give_verdict
  // Register port: one-cycle strobes, read data sampled in the following cycle
  task wr_reg(input logic [7:0] a, input logic [31:0] v);
    @(posedge clk);
    addr <= a; wdata <= v; wr <= 1'h1;
    @(posedge clk);
    wr <= 1'h0;
  endtask : wr_reg
  task rd_reg(input logic [7:0] a);
    @(posedge clk);
    addr <= a; rd <= 1'h1;
    @(posedge clk);
    rd <= 1'h0;
    #1 d = rdata;
  endtask : rd_reg
  task send_out(input logic [4:0] s, input int cnt);
    for (int k = 0; k < cnt; k++) begin
      @(posedge clk);
      out_valid <= 1'h1; out_slot <= s; out_data <= 16'hA500 + k[15:0]; out_last <= (k == cnt - 1);
    end
    @(posedge clk);
    out_valid <= 1'h0; out_last <= 1'h0;
  endtask : send_out
  task wait_hs(input logic v, input int lim);
    n = 0;
    while (hs_mode !== v && n < lim) begin
      @(posedge clk); #1 n++;
    end
  endtask : wait_hs
  task t_reset_srp;
    rd_reg(REG_STATUS); `CHK("status", 32'h0, d)
    rd_reg(8'h1C); `CHK("unmapped", 32'h0, d)
    // Clock enable low: the write must not reach the frozen state
    ce <= 1'h0; wr_reg(REG_CTRL, 32'h1); repeat (3) @(posedge clk);
    `CHK("srp frozen", 1'h0, srp_seen)
    ce <= 1'h1;
    wr_reg(REG_CTRL, 32'h1); repeat (3) @(posedge clk);
    `CHK("srp", 1'h1, srp_seen)
  endtask : t_reset_srp
  // OUT packet of four words drained by DMA with the handshake method
  task t_out_dma;
    wr_reg(REG_CTRL, 32'h0300); wr_reg(REG_EP_CFG, 32'h0100_0045); send_out(SLOT_OUT1, 4);
    rd_reg(REG_EP_STAT); `CHK("stat", 16'h4004, d[15:0])
    wr_reg(REG_DMA_CFG, 32'h1); dma_hs <= 1'h1; wr_reg(REG_DMA_CMD, 32'h8000_0300);
    n = 0;
    repeat (100) begin
      @(posedge clk); #1;
      if (dma_rx_valid === 1'h1) begin `CHK("dma word", 16'hA500 + n[15:0], dma_rx_data) n++; end
    end
    `CHK("dma count", 4, n)
    rd_reg(REG_EP_STAT); `CHK("full after dma", 2'h0, d[15:14])
  endtask : t_out_dma
  // Software read frees the buffer; clear bit empties an unread one
  task t_read_clear;
    send_out(SLOT_OUT1, 2);
    rd_reg(REG_EP_DATA); `CHK("word 0", 32'hA500, d)
    rd_reg(REG_EP_DATA); `CHK("word 1", 32'hA501, d)
    rd_reg(REG_EP_STAT); `CHK("full after read", 2'h0, d[15:14])
    send_out(SLOT_OUT1, 2); wr_reg(REG_CTRL, 32'h0302);
    rd_reg(REG_EP_STAT); `CHK("full after clear", 2'h0, d[15:14])
  endtask : t_read_clear
  task t_in_nak;
    @(posedge clk); in_req <= 1'h1; in_slot <= SLOT_CTRL_IN;
    @(posedge clk); in_req <= 1'h0; seen = 1'h0;
    // Nak stands only in the cycle right after the request is taken
    repeat (3) begin #1 seen = seen | (in_nak === 1'h1); @(posedge clk); end
    `CHK("nak", 1'h1, seen)
  endtask : t_in_nak
  // Strobe-mode DMA into IN1, streamed back out on USB; setup packet flag
  task t_dma_in;
    int k, m;
    k = 0; m = 0; dma_tx_data <= 16'hC300;
    wr_reg(REG_CTRL, 32'h0A00); wr_reg(REG_EP_CFG, 32'h0200_0021);
    rd_reg(REG_EP_CFG); `CHK("cfg", 32'h0200_0021, d)
    wr_reg(REG_DMA_CFG, 32'h0); dma_hs <= 1'h0; wr_reg(REG_DMA_CMD, 32'h8000_0A01);
    repeat (40) begin
      @(posedge clk);
      if (dma_take === 1'h1) begin k++; dma_tx_data <= 16'hC300 + k[15:0]; end
    end
    `CHK("dma takes", 2, k)
    @(posedge clk); in_req <= 1'h1; in_slot <= SLOT_IN1;
    @(posedge clk); in_req <= 1'h0;
    repeat (6) begin
      @(posedge clk); #1;
      if (in_valid === 1'h1) begin
        `CHK("in word", 16'hC300 + m[15:0], in_data)
        `CHK("in last", m == 1, in_last)
        m++;
      end
    end
    `CHK("in count", 2, m)
    send_out(SLOT_SETUP, 4);
    rd_reg(REG_STATUS); `CHK("setup seen", 32'h2, d)
    rd_reg(REG_STATUS); `CHK("setup cleared", 32'h0, d)
  endtask : t_dma_in
  // Chirp, idle revert with and without SE0, then suspend
  task t_speed;
    @(posedge clk); bus_reset <= 1'h1; wait_hs(1'h1, 50); bus_reset <= 1'h0;
    `CHK("hs entry", 1'h1, hs_mode)
    rd_reg(REG_STATUS); `CHK("speed", 2'h2, d[5:4])
    repeat (3) begin repeat (150) @(posedge clk); activity <= 1'h1; @(posedge clk); activity <= 1'h0; end
    `CHK("hs kept", 1'h1, hs_mode)
    wait_hs(1'h0, 300); `CHK("revert time", 1'h1, n >= 190 && hs_mode === 1'h0)
    // A long SE0 is a bus reset, so the host answers the repeated chirp
    se0 <= 1'h1; bus_reset <= 1'h1; repeat (30) @(posedge clk);
    se0 <= 1'h0; bus_reset <= 1'h0; wait_hs(1'h1, 60);
    `CHK("rechirp", 1'h1, hs_mode)
    wait_hs(1'h0, 300); repeat (170) @(posedge clk);
    `CHK("suspend", 1'h1, suspend)
  endtask : t_speed
  initial begin
    {nrst, wr, rd, bus_reset, se0, activity, out_valid, out_last, in_req, dma_hs} = '0;
    {addr, wdata, out_slot, out_data, in_slot, dma_tx_data} = '0; hs_cap = 1'h1; ce = 1'h1;
    err_total = 0; cmp_count = 0;
    repeat (2) @(posedge clk);
    nrst <= 1'h1;
    t_reset_srp(); t_out_dma(); t_read_clear(); t_in_nak(); t_dma_in(); t_speed();
    give_verdict();
  end
  // Hang guard well beyond the expected run of under two thousand cycles
  initial begin
    repeat (20000) @(posedge clk);
    err_total++;
    give_verdict();
  end
endmodule : usb_device_endpoint_core_bench
`default_nettype wire
